// ---- logic/sifd_pkg.sv ----
package sifd_pkg;

  // ==========================================================
  // Instruction word and field positions
  typedef logic [127:0] sifd_word_t;
  localparam int P_OPC = 0;
  localparam int P_LAYOUT = 8;
  localparam int P_COND = 24;
  localparam int P_DST_FILE = 32, P_DST_TYPE = 34, P_S0_FILE = 37, P_S0_TYPE = 39;
  localparam int P_S1_FILE = 42, P_S1_TYPE = 44, P_NIB = 47;
  localparam int P_DST_LO = 48, P_DST_HI4 = 52, P_DST_REG = 53, P_DST_IDX = 58;
  localparam int P_DST_STEP = 61, P_DST_IND = 63;
  localparam int P_SRC0 = 64, P_SRC1 = 96, P_S0_RSV = 91, P_S1_RSV = 121;
  localparam int P_FLAG = 90, P_FLAG_SUB = 89;
  // Source fields, relative to the source's own doubleword
  localparam int R_LO = 0, R_SUB4 = 4, R_IMM_HI = 4, R_REG = 5, R_IDX = 10;
  localparam int R_MOD = 13, R_IND = 15, R_HI = 16, R_WIDTH = 18, R_ROW = 21;
  // Three-source groups and second doubleword
  localparam int P3_GRP = 64, GRP_W = 21, G_REP = 0, G_SWZ = 1, G_SUB = 9, G_REG = 12;
  localparam int G_RSV = 20;
  localparam int P3_FLAG_SUB = 33, P3_FLAG = 34, P3_MOD = 36, P3_STYPE = 42;
  localparam int P3_DTYPE = 44, P3_MASK = 49, P3_SUB = 53, P3_REG = 56;
  localparam logic [127:0] RSV3_MASK = 128'h80000000000000000001400900000000;
  // Variant layouts
  localparam int P_TEND = 127, P_DESC = 96, P_JOIN = 96, P_UPD = 112;

  // ==========================================================
  // Condition codes
  localparam logic [3:0] CC_KEEP = 4'h0, CC_Z = 4'h1, CC_NZ = 4'h2, CC_GT = 4'h3;
  localparam logic [3:0] CC_GE = 4'h4, CC_LT = 4'h5, CC_LE = 4'h6, CC_OV = 4'h8;
  localparam logic [3:0] CC_UN = 4'h9;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0, REG_COUNT = 4'h4, REG_ERRS = 4'h8;
  localparam logic [3:0] REG_LAST = 4'hC;
  localparam int CTRL_EN = 0, CTRL_CLR = 1, LAST_FMT = 8;
  localparam logic CTRL_EN_RST = 1'b1;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {FMT_REGULAR, FMT_THREE_SRC, FMT_SEND, FMT_MATH, FMT_BRANCH} sifd_fmt_t;
  typedef enum logic [3:0] {
    COND_KEEP, COND_ZERO, COND_NONZERO, COND_GT, COND_GE, COND_LT, COND_LE,
    COND_OVERFLOW, COND_UNORDERED, COND_RESERVED
  } sifd_cond_t;

  // Packed to mirror the fixed lowest doubleword bit for bit
  typedef struct packed {
    logic saturate;
    logic debug_flag;
    logic compaction_flag;
    logic accumulator_write_flag;
    logic [3:0] flag_condition_code;
    logic [2:0] simd_width_code;
    logic pred_invert;
    logic [3:0] predication_select;
    logic [1:0] thread_sched_hint;
    logic [1:0] quarter_select;
    logic [1:0] dependency_check_sel;
    logic write_enable_override;
    logic operand_layout_sel;
    logic opcode_reserved;
    logic [6:0] opcode;
  } sifd_ctrl_t;

  typedef struct packed {
    logic [1:0] operand_file_sel;
    logic [2:0] dtype;
    logic indirect_select;
    logic [7:0] reg_num;
    logic [4:0] sub_reg;
    logic [2:0] index_reg_select;
    logic [9:0] addr_imm;
    logic [7:0] channel_swizzle;
    logic [3:0] row_step;
    logic [2:0] width;
    logic [1:0] element_step;
    logic [1:0] source_numeric_modifier;
    logic scalar_replicate;
    logic [3:0] channel_write_mask;
  } sifd_opnd_t;

  typedef struct packed {
    sifd_ctrl_t ctrl;
    sifd_fmt_t fmt;
    sifd_cond_t cond_kind;
    logic flag_update;
    sifd_opnd_t dst;
    sifd_opnd_t [2:0] src;
    logic imm_valid;
    logic [31:0] imm32;
    logic flag_reg_index;
    logic flag_half_index;
    logic nibble_half_select;
    logic [3:0] shared_function_target;
    logic [3:0] math_function_code;
    logic thread_end_flag;
    logic desc_is_reg;
    logic [28:0] msg_descriptor;
    logic [15:0] update_jump_offset;
    logic [15:0] join_jump_offset;
    logic branch_mbz_err;
    logic reserved_err;
  } sifd_dec_t;

endpackage

// ---- logic/sifd_decoder.sv ----
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
module sifd_decoder #(
  parameter int COUNT_W = 16,
  // Opcode and operand file encodings: plain defaults, set per instruction set
  parameter logic [6:0] OP_BFE = 7'h18,
  parameter logic [6:0] OP_BITFIELD_INSERT_OP = 7'h19,
  parameter logic [6:0] OP_LRP = 7'h5C,
  parameter logic [6:0] OP_MAD = 7'h5B,
  parameter logic [6:0] OP_SEND = 7'h31,
  parameter logic [6:0] OP_SENDC = 7'h32,
  parameter logic [6:0] OP_MATH = 7'h38,
  parameter logic [6:0] OP_BR_LO = 7'h20,
  parameter logic [6:0] OP_BR_HI = 7'h2F,
  parameter logic [15:0] BR_TWO_OFFSET_MAP = 16'h0F00,
  parameter logic [1:0] FILE_GRF = 2'h1,
  parameter logic [1:0] FILE_IMM = 2'h3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Instruction fetch side
  input wire logic instr_valid,
  input wire sifd_pkg::sifd_word_t instr_word,
  // Operand fetch side
  output logic dec_valid,
  output sifd_pkg::sifd_dec_t dec_fields,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import sifd_pkg::*;

  // ==========================================================
  // Parameter checks
  if (COUNT_W < 1 || COUNT_W > 32)
  begin : g_bad_count
    $error("COUNT_W must lie in 1..32");
  end
  if (OP_BR_HI < OP_BR_LO || OP_BR_HI - OP_BR_LO > 7'h0F)
  begin : g_bad_branch
    $error("Branch opcode range must span 1..16 codes");
  end

  // ==========================================================
  // State
  typedef struct packed {
    sifd_dec_t dec;
    logic dec_valid;
    logic enable;
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] errs;
    logic [6:0] last_op;
    sifd_fmt_t last_fmt;
    logic waitreq;
    logic [31:0] rdata;
  } sifd_state_t;

  sifd_state_t st_r;
  sifd_state_t st_nxt;

  // ==========================================================
  // Decode helpers
  function automatic sifd_cond_t cond_decode(input logic [3:0] code);
    sifd_cond_t c;
    c = COND_RESERVED;
    case (code)
      CC_KEEP: c = COND_KEEP;
      CC_Z: c = COND_ZERO;
      CC_NZ: c = COND_NONZERO;
      CC_GT: c = COND_GT;
      CC_GE: c = COND_GE;
      CC_LT: c = COND_LT;
      CC_LE: c = COND_LE;
      CC_OV: c = COND_OVERFLOW;
      CC_UN: c = COND_UNORDERED;
      default: c = COND_RESERVED;
    endcase
    return c;
  endfunction

  // One helper for both sources, fed the source's own doubleword
  function automatic sifd_opnd_t decode_src(input logic [31:0] dw, input logic four);
    sifd_opnd_t o;
    o = '0;
    o.indirect_select = dw[R_IND];
    o.source_numeric_modifier = dw[R_MOD +: 2];
    o.row_step = dw[R_ROW +: 4];
    if (o.indirect_select)
    begin
      o.index_reg_select = dw[R_IDX +: 3];
      // Four-channel form drops the low four address bits
      o.addr_imm = four ? {dw[R_IMM_HI +: 6], 4'h0} : dw[R_LO +: 10];
    end
    else
    begin
      o.reg_num = dw[R_REG +: 8];
      o.sub_reg = four ? {dw[R_SUB4], 4'h0} : dw[R_LO +: 5];
    end
    if (four)
    begin
      o.channel_swizzle = {dw[R_HI +: 4], dw[R_LO +: 4]};
    end
    else
    begin
      o.width = dw[R_WIDTH +: 3];
      o.element_step = dw[R_HI +: 2];
    end
    return o;
  endfunction

  function automatic sifd_opnd_t decode_grp(input logic [GRP_W-1:0] g);
    sifd_opnd_t o;
    o = '0;
    o.operand_file_sel = FILE_GRF;
    o.reg_num = g[G_REG +: 8];
    // Doubleword granularity: index becomes byte offset
    o.sub_reg = {g[G_SUB +: 3], 2'b00};
    o.channel_swizzle = g[G_SWZ +: 8];
    o.scalar_replicate = g[G_REP];
    return o;
  endfunction

  function automatic sifd_dec_t decode_instr(input sifd_word_t w);
    sifd_dec_t d;
    logic four;
    logic [6:0] op;
    logic [6:0] br;
    d = '0;
    op = w[P_OPC +: 7];
    four = w[P_LAYOUT];
    br = op - OP_BR_LO;
    d.ctrl = sifd_ctrl_t'(w[31:0]);
    d.reserved_err = d.ctrl.opcode_reserved;
    if (op == OP_BFE || op == OP_BITFIELD_INSERT_OP || op == OP_LRP || op == OP_MAD)
      d.fmt = FMT_THREE_SRC;
    else if (op == OP_SEND || op == OP_SENDC)
      d.fmt = FMT_SEND;
    else if (op == OP_MATH)
      d.fmt = FMT_MATH;
    else if (op >= OP_BR_LO && op <= OP_BR_HI)
      d.fmt = FMT_BRANCH;
    else
      d.fmt = FMT_REGULAR;
    d.nibble_half_select = w[P_NIB];
    if (d.fmt == FMT_THREE_SRC)
    begin
      d.dst.operand_file_sel = FILE_GRF;
      d.dst.dtype = {1'b0, w[P3_DTYPE +: 2]};
      d.dst.reg_num = w[P3_REG +: 8];
      d.dst.sub_reg = {w[P3_SUB +: 3], 2'b00};
      d.dst.channel_write_mask = w[P3_MASK +: 4];
      d.flag_reg_index = w[P3_FLAG];
      d.flag_half_index = w[P3_FLAG_SUB];
      d.reserved_err = d.reserved_err | (|(w & RSV3_MASK));
      for (int i = 0; i < 3; i++)
      begin
        d.src[i] = decode_grp(w[P3_GRP + GRP_W * i +: GRP_W]);
        d.src[i].dtype = {1'b0, w[P3_STYPE +: 2]};
        d.src[i].source_numeric_modifier = w[P3_MOD + 2 * i +: 2];
        d.reserved_err = d.reserved_err | w[P3_GRP + GRP_W * i + G_RSV];
      end
    end
    else
    begin
      d.dst.operand_file_sel = w[P_DST_FILE +: 2];
      d.dst.dtype = w[P_DST_TYPE +: 3];
      d.dst.indirect_select = w[P_DST_IND];
      if (d.dst.indirect_select)
      begin
        d.dst.index_reg_select = w[P_DST_IDX +: 3];
        d.dst.addr_imm = four ? {w[P_DST_HI4 +: 6], 4'h0} : w[P_DST_LO +: 10];
      end
      else
      begin
        d.dst.reg_num = w[P_DST_REG +: 8];
        d.dst.sub_reg = four ? {w[P_DST_HI4], 4'h0} : w[P_DST_LO +: 5];
      end
      // One-channel form writes every channel of the region
      d.dst.channel_write_mask = four ? w[P_DST_LO +: 4] : 4'hF;
      d.dst.element_step = four ? 2'b00 : w[P_DST_STEP +: 2];
      d.src[0] = decode_src(w[P_SRC0 +: 32], four);
      d.src[0].operand_file_sel = w[P_S0_FILE +: 2];
      d.src[0].dtype = w[P_S0_TYPE +: 3];
      d.src[1].operand_file_sel = w[P_S1_FILE +: 2];
      d.src[1].dtype = w[P_S1_TYPE +: 3];
      d.flag_reg_index = w[P_FLAG];
      d.flag_half_index = w[P_FLAG_SUB];
      d.reserved_err = d.reserved_err | (|w[P_S0_RSV +: 5]);
      d.imm_valid = d.src[0].operand_file_sel == FILE_IMM ||
                    d.src[1].operand_file_sel == FILE_IMM;
      if (d.imm_valid && d.fmt != FMT_SEND)
      begin
        d.imm32 = w[P_SRC1 +: 32];
        if (d.src[0].operand_file_sel == FILE_IMM)
          d.src[0] = {d.src[0].operand_file_sel, d.src[0].dtype, 51'h0};
      end
      else if (d.fmt == FMT_REGULAR || d.fmt == FMT_MATH)
      begin
        // Keep file and type from the second doubleword, region fields below them
        d.src[1] = {d.src[1].operand_file_sel, d.src[1].dtype,
                    51'(decode_src(w[P_SRC1 +: 32], four))};
        d.reserved_err = d.reserved_err | (|w[P_S1_RSV +: 7]);
      end
    end
    case (d.fmt)
      FMT_SEND:
      begin
        d.shared_function_target = w[P_COND +: 4];
        d.thread_end_flag = w[P_TEND];
        d.desc_is_reg = d.src[1].operand_file_sel != FILE_IMM;
        d.imm_valid = 1'b0;
        if (!d.desc_is_reg)
          d.msg_descriptor = w[P_DESC +: 29];
        else
          d.src[1] = {d.src[1].operand_file_sel, d.src[1].dtype,
                      51'(decode_src(w[P_SRC1 +: 32], four))};
      end
      FMT_MATH:
        d.math_function_code = w[P_COND +: 4];
      FMT_BRANCH:
      begin
        d.branch_mbz_err = |w[P_COND +: 4];
        d.join_jump_offset = w[P_JOIN +: 16];
        if (BR_TWO_OFFSET_MAP[br[3:0]])
          d.update_jump_offset = w[P_UPD +: 16];
      end
      default:
      begin
        d.cond_kind = cond_decode(d.ctrl.flag_condition_code);
        d.flag_update = d.ctrl.flag_condition_code != CC_KEEP;
      end
    endcase
    return d;
  endfunction

  // ==========================================================
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.dec_valid = 1'b0;
    st_nxt.waitreq = 1'b1;
    // One wait cycle per access, then a single ready cycle
    if ((avs_read || avs_write) && st_r.waitreq)
    begin
      st_nxt.waitreq = 1'b0;
      st_nxt.rdata = '0;
      if (avs_read)
      begin
        if (avs_address == REG_CTRL)
          st_nxt.rdata[CTRL_EN] = st_r.enable;
        else if (avs_address == REG_COUNT)
          st_nxt.rdata = 32'(st_r.count);
        else if (avs_address == REG_ERRS)
          st_nxt.rdata = 32'(st_r.errs);
        else if (avs_address == REG_LAST)
          st_nxt.rdata = {21'h0, st_r.last_fmt, 1'b0, st_r.last_op};
        else
          st_nxt.rdata = '0;
      end
    end
    if (avs_write && !st_r.waitreq && avs_address == REG_CTRL && avs_byteenable[0])
    begin
      st_nxt.enable = avs_writedata[CTRL_EN];
      if (avs_writedata[CTRL_CLR])
      begin
        st_nxt.count = '0;
        st_nxt.errs = '0;
      end
    end
    // Decode after clear so a same-cycle instruction still counts
    if (instr_valid && st_r.enable)
    begin
      st_nxt.dec = decode_instr(instr_word);
      st_nxt.dec_valid = 1'b1;
      st_nxt.count = st_nxt.count + 1'b1;
      st_nxt.last_op = st_nxt.dec.ctrl.opcode;
      st_nxt.last_fmt = st_nxt.dec.fmt;
      if (st_nxt.dec.reserved_err || st_nxt.dec.branch_mbz_err)
        st_nxt.errs = st_nxt.errs + 1'b1;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= '0;
      st_r.enable <= CTRL_EN_RST;
      st_r.waitreq <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign dec_valid = st_r.dec_valid;
  assign dec_fields = st_r.dec;
  assign avs_readdata = st_r.rdata;
  assign avs_waitrequest = st_r.waitreq;

endmodule // sifd_decoder

// ---- dv/sifd_decoder_sva.sv ----
`timescale 1ns/100ps
// ==========================================================
// Decoder port checks
module sifd_decoder_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Instruction side
  input wire logic instr_valid,
  input wire sifd_pkg::sifd_word_t instr_word,
  input wire logic dec_valid,
  input wire sifd_pkg::sifd_dec_t dec_fields,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  import sifd_pkg::*;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  AST_PULSE_CAUSE: assert property (dec_valid |-> $past(instr_valid))
    else $error("decode pulse without a fetched word");
  AST_FIELDS_HOLD: assert property (!dec_valid |-> $stable(dec_fields))
    else $error("decoded fields moved without a decode");
  AST_OPCODE: assert property (dec_valid |-> dec_fields.ctrl.opcode == $past(instr_word[6:0]))
    else $error("opcode field wrong");
  AST_DW0_FIELDS: assert property (dec_valid |-> dec_fields.ctrl == $past(instr_word[31:0]))
    else $error("lowest doubleword fields wrong");
  AST_THREE_SRC: assert property (dec_valid |-> ((dec_fields.fmt == FMT_THREE_SRC) ==
    ($past(instr_word[6:0]) inside {7'h18, 7'h19, 7'h5C, 7'h5B})))
    else $error("three-source layout chosen wrongly");
  AST_DW1_FILES: assert property (dec_valid && dec_fields.fmt == FMT_REGULAR |->
    dec_fields.dst.operand_file_sel == $past(instr_word[33:32])
    && dec_fields.dst.dtype == $past(instr_word[36:34]))
    else $error("destination file or type wrong");
  AST_IMM_WORD: assert property (dec_valid && dec_fields.imm_valid |->
    dec_fields.imm32 == $past(instr_word[127:96]))
    else $error("immediate value wrong");
  AST_COND_KEEP: assert property (dec_valid && dec_fields.fmt == FMT_REGULAR
    && dec_fields.ctrl.flag_condition_code == CC_KEEP |-> !dec_fields.flag_update)
    else $error("flag update on keep code");
  AST_SEND_TARGET: assert property (dec_valid && dec_fields.fmt == FMT_SEND |->
    dec_fields.shared_function_target == $past(instr_word[27:24]))
    else $error("send target wrong");
  AST_BRANCH_MBZ: assert property (dec_valid && dec_fields.fmt == FMT_BRANCH |->
    dec_fields.branch_mbz_err == ($past(instr_word[27:24]) != 4'h0))
    else $error("branch zero field check wrong");
  AST_BUS_ONE_WAIT: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  COV_THREE_SRC: cover property (dec_valid && dec_fields.fmt == FMT_THREE_SRC);
  COV_SEND: cover property (dec_valid && dec_fields.fmt == FMT_SEND);
  COV_BUS: cover property ((avs_read || avs_write) && !avs_waitrequest);
endmodule // sifd_decoder_sva

// ---- dv/sifd_fetch_model.sv ----
`timescale 1ns/100ps
// ==========================================================
// Fetch unit stand-in, one word per request
module sifd_fetch_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Request from the bench
  input wire logic issue,
  input wire sifd_pkg::sifd_word_t issue_word,
  // Toward the decoder
  output logic instr_valid,
  output sifd_pkg::sifd_word_t instr_word
);
  import sifd_pkg::*;

  // Idle word toggles: a decoder sampling without valid shows up
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      instr_valid <= 1'b0;
      instr_word <= '0;
    end
    else
    begin
      instr_valid <= issue;
      instr_word <= issue ? issue_word : ~instr_word;
    end
  end
endmodule // sifd_fetch_model

// ---- dv/sifd_decoder_tb_top.sv ----
`timescale 1ns/100ps
module sifd_decoder_tb_top;
  import sifd_pkg::*;
  logic core_clk, rstn, iss, instr_valid, dec_valid, avs_read, avs_write, avs_waitrequest;
  sifd_word_t iw, instr_word, w;
  sifd_dec_t df;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int errors, comparisons, ndec;
  localparam sifd_word_t W_REG = {32'h01C21234, 32'h05436789, 32'h4239E5D5, 32'h03256401};
  logic [6:0] ops3 [4] = '{7'h18, 7'h19, 7'h5C, 7'h5B};
  sifd_cond_t ctab [16] = '{0: COND_KEEP, 1: COND_ZERO, 2: COND_NONZERO, 3: COND_GT,
    4: COND_GE, 5: COND_LT, 6: COND_LE, 8: COND_OVERFLOW, 9: COND_UNORDERED,
    default: COND_RESERVED};

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  sifd_fetch_model sifd_fetch_model_inst (.core_clk(core_clk), .rstn(rstn), .issue(iss),
    .issue_word(iw), .instr_valid(instr_valid), .instr_word(instr_word));
  sifd_decoder sifd_decoder_inst (.core_clk(core_clk), .rstn(rstn),
    .instr_valid(instr_valid), .instr_word(instr_word), .dec_valid(dec_valid),
    .dec_fields(df), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  // ==========================================================
  // Checking and access tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] be);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    // Values read right at the edge are the ones the edge sampled
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    // One wait cycle, answer sampled at the second edge
    chk("bus answer", 32'h2, 32'(n));
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(name, exp, rd);
  endtask

  task automatic issue(input sifd_word_t x, input logic exp_v);
    @(posedge core_clk);
    iss <= 1'b1;
    iw <= x;
    @(posedge core_clk);
    iss <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("decode pulse", 32'(exp_v), 32'(dec_valid));
    ndec += int'(exp_v);
  endtask

  initial
  begin
    repeat (5000) @(posedge core_clk);
    errors++;
    print_verdict();
  end

  // ==========================================================
  // Test sequence
  initial
  begin
    rstn = 1'b0;
    iss = 1'b0;
    iw = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    errors = 0;
    comparisons = 0;
    ndec = 0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    rd_chk("ctrl reset", REG_CTRL, 32'h1);
    rd_chk("count reset", REG_COUNT, 32'h0);
    rd_chk("errs reset", REG_ERRS, 32'h0);
    rd_chk("unmapped", 4'h2, 32'h0);
    w = W_REG;
    issue(w, 1'b1);
    chk("dst file", 32'(w[33:32]), 32'(df.dst.operand_file_sel));
    chk("src0 file", 32'(w[38:37]), 32'(df.src[0].operand_file_sel));
    chk("src1 type", 32'(w[46:44]), 32'(df.src[1].dtype));
    chk("nibble", 32'(w[47]), 32'(df.nibble_half_select));
    chk("src0 row", 32'(w[88:85]), 32'(df.src[0].row_step));
    chk("src0 mod", 32'(w[78:77]), 32'(df.src[0].source_numeric_modifier));
    chk("flag reg", 32'(w[90]), 32'(df.flag_reg_index));
    chk("src1 row", 32'(w[120:117]), 32'(df.src[1].row_step));
    chk("src0 reg", 32'(w[76:69]), 32'(df.src[0].reg_num));
    chk("src1 reg", 32'(w[108:101]), 32'(df.src[1].reg_num));
    chk("dst step", 32'(w[62:61]), 32'(df.dst.element_step));
    chk("fmt", 32'(FMT_REGULAR), 32'(df.fmt));
    for (int lay = 0; lay < 2; lay++)
    begin
      w = W_REG;
      w[79] = 1'b1;
      w[8] = lay[0];
      issue(w, 1'b1);
      chk("src0 ind", 32'h1, 32'(df.src[0].indirect_select));
      chk("src0 index", 32'(w[76:74]), 32'(df.src[0].index_reg_select));
      chk("src0 imm", lay ? 32'({w[73:68], 4'h0}) : 32'(w[73:64]), 32'(df.src[0].addr_imm));
      chk("dst mask", lay ? 32'(w[51:48]) : 32'hF, 32'(df.dst.channel_write_mask));
    end
    foreach (ops3[i])
    begin
      w = W_REG;
      w[6:0] = ops3[i];
      issue(w, 1'b1);
      chk("fmt three", 32'(FMT_THREE_SRC), 32'(df.fmt));
    end
    chk("src2 reg", 32'(w[125:118]), 32'(df.src[2].reg_num));
    chk("src2 swz", 32'(w[114:107]), 32'(df.src[2].channel_swizzle));
    chk("src1 reg3", 32'(w[104:97]), 32'(df.src[1].reg_num));
    chk("src0 reg3", 32'(w[83:76]), 32'(df.src[0].reg_num));
    chk("src0 rep", 32'(w[64]), 32'(df.src[0].scalar_replicate));
    chk("dst reg3", 32'(w[63:56]), 32'(df.dst.reg_num));
    chk("dst mask3", 32'(w[52:49]), 32'(df.dst.channel_write_mask));
    chk("flag reg3", 32'(w[34]), 32'(df.flag_reg_index));
    chk("src2 mod", 32'(w[41:40]), 32'(df.src[2].source_numeric_modifier));
    chk("src0 mod3", 32'(w[37:36]), 32'(df.src[0].source_numeric_modifier));
    w = W_REG;
    w[43:42] = 2'h3;
    issue(w, 1'b1);
    chk("imm valid", 32'h1, 32'(df.imm_valid));
    chk("imm", w[127:96], df.imm32);
    w[6:0] = 7'h31;
    w[127] = 1'b1;
    issue(w, 1'b1);
    chk("target", 32'(w[27:24]), 32'(df.shared_function_target));
    chk("thread end", 32'h1, 32'(df.thread_end_flag));
    chk("descriptor", 32'(w[124:96]), 32'(df.msg_descriptor));
    w[6:0] = 7'h38;
    issue(w, 1'b1);
    chk("math fc", 32'(w[27:24]), 32'(df.math_function_code));
    w = W_REG;
    w[6:0] = 7'h28;
    issue(w, 1'b1);
    chk("mbz err", 32'h1, 32'(df.branch_mbz_err));
    chk("update", 32'(w[127:112]), 32'(df.update_jump_offset));
    for (int c = 0; c < 16; c++)
    begin
      w = W_REG;
      w[27:24] = c[3:0];
      issue(w, 1'b1);
      chk("cond kind", 32'(ctab[c]), 32'(df.cond_kind));
    end
    // Back to back words, both must decode
    @(posedge core_clk);
    iss <= 1'b1;
    iw <= W_REG;
    @(posedge core_clk);
    iw <= w;
    @(posedge core_clk);
    iss <= 1'b0;
    #1;
    chk("first pulse", 32'h1, 32'(dec_valid));
    chk("first cond", 32'(W_REG[27:24]), 32'(df.ctrl.flag_condition_code));
    @(posedge core_clk);
    #1;
    chk("second pulse", 32'h1, 32'(dec_valid));
    chk("second cond", 32'(w[27:24]), 32'(df.ctrl.flag_condition_code));
    ndec += 2;
    rd_chk("count", REG_COUNT, 32'(ndec));
    rd_chk("last", REG_LAST, {21'h0, 3'(FMT_REGULAR), 1'b0, w[6:0]});
    bus(1'b1, REG_CTRL, 32'h0, 4'h0);
    rd_chk("ctrl lane off", REG_CTRL, 32'h1);
    bus(1'b1, REG_CTRL, 32'h0, 4'h1);
    issue(W_REG, 1'b0);
    rd_chk("count held", REG_COUNT, 32'(ndec));
    bus(1'b1, REG_CTRL, 32'h3, 4'h1);
    rd_chk("count clear", REG_COUNT, 32'h0);
    rd_chk("ctrl back", REG_CTRL, 32'h1);
    issue(W_REG, 1'b1);
    print_verdict();
  end
endmodule // sifd_decoder_tb_top

bind sifd_decoder sifd_decoder_sva sifd_decoder_sva_inst (.core_clk(core_clk), .rstn(rstn),
  .instr_valid(instr_valid), .instr_word(instr_word), .dec_valid(dec_valid),
  .dec_fields(dec_fields), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest));
